// *** src/cpu_status_special_registers.v ***
// Bank of 16-bit CPU status registers behind an APB slave.
// Assumes event inputs synchronous to pclk; clock time comes from outside.
//
// Functional notes
// [R1] Fuse register takes lowest blown module number
// [R2] Count supply dips while running, binary
// [R3] Store self-diagnosis error number in binary
// [R4] Stamp year and month BCD on update
// [R5] Stamp day and hour BCD on update
// [R6] Stamp minute and second BCD on update
// [R7] Class code: none, unit number, parameter
// [R8] Info value holds detail; CPU 1-4
// [R9] Each main pass: state 0 run, 2 stop
// [R10] Stop cause 0 switch, 4 error; earliest wins
// [R11] Last main cycle length in milliseconds
// [R12] Largest main cycle length in milliseconds
// [R13] Clock year/month BCD, written by device or user
// [R14] Values stored as plain binary by default
// [R15] State bits 3:0, cause bits 7:4, rest zero
// [R16] Stamps load with error number, same cycle
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "special_regs_map.vh"

module cpu_status_special_registers #(
  parameter NUM_MODULES = 64,
  parameter MS_CYCLES = `MS_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [NUM_MODULES-1:0] fuse_blown,
  input wire supply_dip,
  input wire diag_error,
  input wire [15:0] diag_error_code,
  input wire [1:0] diag_info_class,
  input wire [15:0] diag_info_value,
  input wire [15:0] time_day_hour,
  input wire [15:0] time_minute_second,
  input wire clock_set,
  input wire [15:0] clock_set_year_month,
  input wire run_switch,
  input wire error_stop,
  input wire main_pass,
  output wire irq
);

  // ==========================================================
  // Register storage
  reg [15:0] blown_fuse_module_number;
  reg [15:0] supply_dip_count;
  reg [15:0] diagnostic_error_number;
  reg [15:0] error_stamp_year_month;
  reg [15:0] error_stamp_day_hour;
  reg [15:0] error_stamp_minute_second;
  reg [15:0] error_info_class;
  reg [15:0] error_info_value;
  reg [3:0] op_state;
  reg [3:0] stop_cause;
  reg [15:0] main_cycle_time_ms;
  reg [15:0] main_cycle_time_max_ms;
  reg [15:0] clock_year_month;
  reg [`IRQ_BITS-1:0] irq_status;
  reg [`IRQ_BITS-1:0] irq_mask;
  reg fuse_seen;
  reg [31:0] next_prdata;
  reg next_err;
  reg read_err;

  wire fuse_any;
  wire [15:0] fuse_index;
  wire [15:0] cycle_ms;
  wire cycle_done;
  wire [15:0] cpu_operating_state;
  wire setup_phase;
  wire write_access;
  wire running;
  wire stop_request;
  wire [`IRQ_BITS-1:0] irq_events;
  wire [`IRQ_BITS-1:0] irq_clear;

  // ==========================================================
  // Register write match, shared by all writable registers
  function wr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = (addr == ofs);
    end
  endfunction

  // ==========================================================
  // Helper blocks
  lowest_index_encoder #(
    .WIDTH(NUM_MODULES)
  ) lowest_index_encoder_i (
    .req(fuse_blown),
    .any(fuse_any),
    .index(fuse_index)
  );

  main_cycle_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) main_cycle_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .cycle_mark(main_pass),
    .cycle_ms(cycle_ms),
    .cycle_done(cycle_done)
  );

  // ==========================================================
  // APB handshake
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign write_access = psel && penable && pwrite;
  assign pslverr = psel && penable && read_err;

  // ==========================================================
  // Blown fuse module number
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blown_fuse_module_number <= `RST_REG16;
      fuse_seen <= 1'b0;
    end
    else
    begin
      fuse_seen <= fuse_any;
      if (fuse_any)
        blown_fuse_module_number <= fuse_index; // R1
    end
  end

  // ==========================================================
  // Supply dip counter
  assign running = (op_state == `STATE_RUN);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      supply_dip_count <= `RST_REG16;
    else if (supply_dip && running)
      supply_dip_count <= supply_dip_count + 16'h0001; // R2 R14
  end

  // ==========================================================
  // Diagnostic error number, stamps and detail
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      diagnostic_error_number <= `RST_REG16;
      error_stamp_year_month <= `RST_REG16;
      error_stamp_day_hour <= `RST_REG16;
      error_stamp_minute_second <= `RST_REG16;
      error_info_class <= `INFO_CLASS_NONE;
      error_info_value <= `RST_REG16;
    end
    else if (diag_error)
    begin
      diagnostic_error_number <= diag_error_code; // R3 R14
      error_stamp_year_month <= clock_year_month; // R4 R16
      error_stamp_day_hour <= time_day_hour; // R5 R16
      error_stamp_minute_second <= time_minute_second; // R6 R16
      if (diag_info_class == 2'b01)
        error_info_class <= `INFO_CLASS_UNIT; // R7
      else if (diag_info_class == 2'b10)
        error_info_class <= `INFO_CLASS_PARAM; // R7
      else
        error_info_class <= `INFO_CLASS_NONE; // R7
      if (diag_info_class == 2'b01 || diag_info_class == 2'b10)
        error_info_value <= diag_info_value; // R8
      else
        error_info_value <= `RST_REG16;
    end
  end

  // ==========================================================
  // Operating state updated each main pass; stop cause kept on passes that stay stopped
  assign stop_request = !run_switch || error_stop;
  assign cpu_operating_state = {8'h00, stop_cause, op_state}; // R15

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_state <= `STATE_STOP;
      stop_cause <= `CAUSE_SWITCH;
    end
    else if (main_pass)
    begin
      if (!stop_request)
      begin
        op_state <= `STATE_RUN; // R9
        stop_cause <= `CAUSE_SWITCH;
      end
      else
      begin
        op_state <= `STATE_STOP; // R9
        if (running)
          stop_cause <= error_stop ? `CAUSE_ERROR : `CAUSE_SWITCH; // R10
      end
    end
  end

  // ==========================================================
  // Cycle times
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_cycle_time_ms <= `RST_REG16;
      main_cycle_time_max_ms <= `RST_REG16;
    end
    else if (cycle_done)
    begin
      main_cycle_time_ms <= cycle_ms; // R11
      if (cycle_ms > main_cycle_time_max_ms)
        main_cycle_time_max_ms <= cycle_ms; // R12
    end
  end

  // ==========================================================
  // Clock year/month, device request beats a user write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_year_month <= `RST_CLOCK_YEAR_MONTH;
    else if (clock_set)
      clock_year_month <= clock_set_year_month; // R13
    else if (write_access && wr_hit(paddr, `OFS_CLOCK_YEAR_MONTH))
      clock_year_month <= pwdata[15:0]; // R13
  end

  // ==========================================================
  // Interrupts: sticky, write one to clear, set wins
  assign irq_events[`IRQ_FUSE] = fuse_any && !fuse_seen;
  assign irq_events[`IRQ_DIP] = supply_dip && running;
  assign irq_events[`IRQ_DIAG] = diag_error;
  assign irq_events[`IRQ_STOP] = main_pass && running && stop_request;
  assign irq_clear = (write_access && wr_hit(paddr, `OFS_IRQ_STATUS)) ? pwdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
  assign irq = |(irq_status & irq_mask);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= {`IRQ_BITS{1'b0}};
      irq_mask <= `RST_IRQ_MASK;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      if (write_access && wr_hit(paddr, `OFS_IRQ_MASK))
        irq_mask <= pwdata[`IRQ_BITS-1:0];
    end
  end

  // ==========================================================
  // Read decode, captured in the setup phase
  always @*
  begin
    next_err = 1'b0;
    next_prdata = 32'h00000000;
    if (paddr == `OFS_BLOWN_FUSE_MODULE_NUMBER)
      next_prdata = {16'h0000, blown_fuse_module_number};
    else if (paddr == `OFS_SUPPLY_DIP_COUNT)
      next_prdata = {16'h0000, supply_dip_count};
    else if (paddr == `OFS_DIAGNOSTIC_ERROR_NUMBER)
      next_prdata = {16'h0000, diagnostic_error_number};
    else if (paddr == `OFS_ERROR_STAMP_YEAR_MONTH)
      next_prdata = {16'h0000, error_stamp_year_month};
    else if (paddr == `OFS_ERROR_STAMP_DAY_HOUR)
      next_prdata = {16'h0000, error_stamp_day_hour};
    else if (paddr == `OFS_ERROR_STAMP_MINUTE_SECOND)
      next_prdata = {16'h0000, error_stamp_minute_second};
    else if (paddr == `OFS_ERROR_INFO_CLASS)
      next_prdata = {16'h0000, error_info_class};
    else if (paddr == `OFS_ERROR_INFO_VALUE)
      next_prdata = {16'h0000, error_info_value};
    else if (paddr == `OFS_CPU_OPERATING_STATE)
      next_prdata = {16'h0000, cpu_operating_state};
    else if (paddr == `OFS_MAIN_CYCLE_TIME_MS)
      next_prdata = {16'h0000, main_cycle_time_ms};
    else if (paddr == `OFS_MAIN_CYCLE_TIME_MAX_MS)
      next_prdata = {16'h0000, main_cycle_time_max_ms};
    else if (paddr == `OFS_CLOCK_YEAR_MONTH)
      next_prdata = {16'h0000, clock_year_month};
    else if (paddr == `OFS_IRQ_STATUS)
      next_prdata = {28'h0000000, irq_status};
    else if (paddr == `OFS_IRQ_MASK)
      next_prdata = {28'h0000000, irq_mask};
    else
      next_err = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      read_err <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      read_err <= next_err;
    end
  end

endmodule // cpu_status_special_registers

// *** src/special_regs_map.vh ***
// Register offsets, field positions, reset values and timing counts
// for the CPU status register bank. Assumes a 32-bit APB slave at 50 MHz.
`ifndef SPECIAL_REGS_MAP_VH
`define SPECIAL_REGS_MAP_VH

// ==========================================================
// Register byte offsets
`define OFS_BLOWN_FUSE_MODULE_NUMBER 8'h00
`define OFS_SUPPLY_DIP_COUNT 8'h04
`define OFS_DIAGNOSTIC_ERROR_NUMBER 8'h08
`define OFS_ERROR_STAMP_YEAR_MONTH 8'h0C
`define OFS_ERROR_STAMP_DAY_HOUR 8'h10
`define OFS_ERROR_STAMP_MINUTE_SECOND 8'h14
`define OFS_ERROR_INFO_CLASS 8'h18
`define OFS_ERROR_INFO_VALUE 8'h1C
`define OFS_CPU_OPERATING_STATE 8'h20
`define OFS_MAIN_CYCLE_TIME_MS 8'h24
`define OFS_MAIN_CYCLE_TIME_MAX_MS 8'h28
`define OFS_CLOCK_YEAR_MONTH 8'h2C
`define OFS_IRQ_STATUS 8'h30
`define OFS_IRQ_MASK 8'h34

// ==========================================================
// Field positions and codes
`define STATE_LSB 0
`define STATE_MSB 3
`define CAUSE_LSB 4
`define CAUSE_MSB 7
`define STATE_RUN 4'h0
`define STATE_STOP 4'h2
`define CAUSE_SWITCH 4'h0
`define CAUSE_ERROR 4'h4
`define INFO_CLASS_NONE 16'h0000
`define INFO_CLASS_UNIT 16'h0001
`define INFO_CLASS_PARAM 16'h0002

// ==========================================================
// Interrupt status bits
`define IRQ_FUSE 0
`define IRQ_DIP 1
`define IRQ_DIAG 2
`define IRQ_STOP 3
`define IRQ_BITS 4

// ==========================================================
// Reset values
`define RST_REG16 16'h0000
`define RST_CLOCK_YEAR_MONTH 16'h0001
`define RST_IRQ_MASK 4'h0

// ==========================================================
// Timing
`define CLK_PERIOD_NS 20
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)

`endif

// *** src/lowest_index_encoder.v ***
// Finds the lowest set bit of a request vector.
// Assumes a synchronous, combinational use by the register bank.
`timescale 1ns/1ps

module lowest_index_encoder #(
  parameter WIDTH = 64
) (
  input wire [WIDTH-1:0] req,
  output reg any,
  output reg [15:0] index
);

  integer i;

  // ==========================================================
  // Scan from the top so the lowest set bit wins
  always @*
  begin
    any = 1'b0;
    index = 16'h0000;
    for (i = WIDTH - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        any = 1'b1;
        index = i[15:0];
      end
    end
  end

endmodule // lowest_index_encoder

// *** src/main_cycle_timer.v ***
// Measures main-cycle length in millisecond units.
// Assumes cycle_mark pulses once at each main pass boundary.
`timescale 1ns/1ps

module main_cycle_timer #(
  parameter MS_CYCLES = 50000
) (
  input wire pclk,
  input wire presetn,
  input wire cycle_mark,
  output reg [15:0] cycle_ms,
  output reg cycle_done
);

  reg [31:0] div;
  reg [15:0] ms_count;
  wire ms_tick;

  // ==========================================================
  // One-millisecond enable divider
  assign ms_tick = (div == MS_CYCLES - 1);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= 32'h00000000;
    else if (cycle_mark || ms_tick)
      div <= 32'h00000000;
    else
      div <= div + 32'h00000001;
  end

  // ==========================================================
  // Millisecond count, saturating at full scale
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_count <= 16'h0000;
      cycle_ms <= 16'h0000;
      cycle_done <= 1'b0;
    end
    else
    begin
      cycle_done <= cycle_mark;
      if (cycle_mark)
      begin
        // A tick landing on the mark still closes a whole millisecond
        if (ms_tick && ms_count != 16'hFFFF)
          cycle_ms <= ms_count + 16'h0001; // R11
        else
          cycle_ms <= ms_count; // R11
        ms_count <= 16'h0000;
      end
      else if (ms_tick && ms_count != 16'hFFFF)
        ms_count <= ms_count + 16'h0001;
    end
  end

endmodule // main_cycle_timer

// *** test/status_monitor.sv ***
// Concurrent checks on the status register bank ports.
// Assumes binding to the bank top; one clock domain.
`timescale 1ns/1ps
module status_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire diag_error,
  input wire [15:0] diag_error_code,
  input wire [15:0] time_day_hour,
  input wire clock_set,
  input wire run_switch,
  input wire error_stop,
  input wire main_pass
);
  // ==========================================================
  // Setup phase of a read
  wire rd = psel && !penable && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  upper_zero_a: assert property (rd |=> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  state_code_a: assert property (rd && paddr == 8'h20 |=> prdata[3:0] == 4'h0 || prdata[3:0] == 4'h2)
    else $error("bad state code");
  cause_code_a: assert property (rd && paddr == 8'h20 |=> prdata[7:4] inside {4'h0, 4'h4})
    else $error("bad stop cause");
  state_pad_a: assert property (rd && paddr == 8'h20 |=> prdata[15:8] == 8'h00)
    else $error("state padding not zero");
  run_cause_a: assert property (rd && paddr == 8'h20 |=> prdata[3:0] != 4'h0 || prdata[7:4] == 4'h0)
    else $error("cause set while running");
  run_pass_a: assert property (main_pass && run_switch && !error_stop ##1 rd && paddr == 8'h20
    |=> prdata[7:0] == 8'h00) else $error("not running after pass");
  class_code_a: assert property (rd && paddr == 8'h18 |=> prdata[15:0] <= 16'h0002)
    else $error("bad class code");
  diag_num_a: assert property (diag_error ##1 rd && paddr == 8'h08
    |=> prdata[15:0] == $past(diag_error_code, 2)) else $error("error number not stored");
  diag_stamp_a: assert property (diag_error ##1 rd && paddr == 8'h10
    |=> prdata[15:0] == $past(time_day_hour, 2)) else $error("stamp not with error");
  clock_wr_a: assert property (psel && penable && pwrite && paddr == 8'h2C && !clock_set ##1 !clock_set
    ##1 rd && paddr == 8'h2C |=> prdata[15:0] == $past(pwdata[15:0], 3)) else $error("clock write lost");
endmodule // status_monitor

bind cpu_status_special_registers status_monitor status_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .diag_error(diag_error), .diag_error_code(diag_error_code), .time_day_hour(time_day_hour),
  .clock_set(clock_set), .run_switch(run_switch), .error_stop(error_stop), .main_pass(main_pass));

// *** test/cpu_status_special_registers_tb.sv ***
// Self-checking bench for the status register bank.
// Assumes the bank sources and the bound monitor.
`timescale 1ns/1ps
module cpu_status_special_registers_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, err;
  logic [15:0] fb = 16'h0, code = 16'h0, dh = 16'h0, ms = 16'h0, ym = 16'h0, info = 16'h0, fv;
  logic [1:0] cls = 2'h0;
  logic dip = 1'b0, diag = 1'b0, cset = 1'b0, rs = 1'b0, es = 1'b0, mp = 1'b0;
  logic [3:0] sw = 4'h5, ef = 4'h1;
  int num_errors = 0, n_tests = 0, k, exp, nd, e_c, e_d, e_m, e_i;
  int ix[9] = '{0, 1, 2, 3, 4, 5, 4, 5, 4};
  int st[4] = '{32'h42, 32'h42, 32'h0, 32'h2};
  cpu_status_special_registers #(.NUM_MODULES(16), .MS_CYCLES(10)) cpu_status_special_registers_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fuse_blown(fb),
    .supply_dip(dip), .diag_error(diag), .diag_error_code(code), .diag_info_class(cls),
    .diag_info_value(info), .time_day_hour(dh), .time_minute_second(ms), .clock_set(cset),
    .clock_set_year_month(ym), .run_switch(rs), .error_stop(es), .main_pass(mp), .irq(irq));
  always #10 pclk = ~pclk;
  // ==========================================================
  // Tasks
  task chk(input string n, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    {mp, dip, diag, cset} <= 4'h0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string n, input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task pulse(input int s);
    @(posedge pclk);
    case (s)
      0: mp <= 1'b1;
      1: dip <= 1'b1;
      2: diag <= 1'b1;
      default: cset <= 1'b1;
    endcase
  endtask
  task idle;
    @(posedge pclk);
    {mp, dip, diag, cset} <= 4'h0;
  endtask
  function int bcd(input int n);
    return (n / 10) * 16 + n % 10;
  endfunction
  task summarize;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    k = $urandom(32'h3CBB);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 14; i++) rdc("reset", 8'(4 * i), i == 11 ? 1 : i == 8 ? 2 : 0);
    apb(1'b1, 8'h08, 32'h1234);
    rdc("read only", 8'h08, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    $display("reset test done");
    rs <= 1'b1;
    pulse(0);
    idle;
    repeat (298) @(posedge pclk);
    pulse(0);
    repeat (3) idle;
    apb(1'b0, 8'h24, 32'h0);
    k = rd;
    chk("cycle", 32'h1E, k);
    rdc("max", 8'h28, k);
    rdc("run", 8'h20, 32'h0);
    pulse(0);
    idle;
    repeat (23) @(posedge pclk);
    pulse(0);
    repeat (3) idle;
    rdc("max kept", 8'h28, k);
    apb(1'b0, 8'h24, 32'h0);
    chk("cycle short", 32'h2, rd);
    $display("cycle test done");
    nd = $urandom_range(3, 9);
    repeat (nd)
    begin
      pulse(1);
      idle;
    end
    rdc("dips", 8'h04, nd);
    apb(1'b1, 8'h34, 32'h2);
    #1 chk("irq on", 32'h1, irq);
    apb(1'b1, 8'h30, 32'h2);
    #1 chk("irq off", 32'h0, irq);
    repeat (2)
    begin
      fv = 16'($urandom) | 16'h8000;
      fb <= fv;
      for (k = 15; k >= 0; k--) if (fv[k]) exp = k;
      idle;
      idle;
      fb <= 16'h0;
      rdc("fuse", 8'h00, exp);
    end
    ym <= 16'h9307;
    pulse(3);
    rdc("clock set", 8'h2C, 32'h9307);
    apb(1'b1, 8'h2C, 32'hFFFF2412);
    rdc("clock write", 8'h2C, 32'h2412);
    $display("event test done");
    for (int i = 0; i < 9; i++)
    begin
      e_c = $urandom_range(0, 65535);
      e_d = bcd($urandom_range(1, 31)) * 256 + bcd($urandom_range(0, 23));
      e_m = bcd($urandom_range(0, 59)) * 256 + bcd($urandom_range(0, 59));
      e_i = $urandom_range(1, 4);
      code <= 16'(e_c);
      dh <= 16'(e_d);
      ms <= 16'(e_m);
      info <= 16'(e_i);
      cls <= 2'(i % 3);
      pulse(2);
      case (ix[i])
        0: exp = e_c;
        1: exp = 32'h2412;
        2: exp = e_d;
        3: exp = e_m;
        4: exp = i % 3;
        default: exp = i % 3 ? e_i : 0;
      endcase
      rdc("diag", 8'(8 + 4 * ix[i]), exp);
    end
    $display("diag test done");
    for (int i = 0; i < 4; i++)
    begin
      rs <= sw[i];
      es <= ef[i];
      pulse(0);
      rdc("stop", 8'h20, st[i]);
    end
    pulse(1);
    idle;
    rdc("dips stopped", 8'h04, nd);
    $display("stop test done");
    summarize;
  end
  initial
  begin
    #(20 * 6000);
    num_errors++;
    summarize;
  end
endmodule // cpu_status_special_registers_tb
